//--- rtl/ais_code.sv
`timescale 1ns/10ps
`default_nettype none

module ais_code (
	input wire logic [3:0] mode,
	input wire logic signed [12:0] raw,
	output logic [15:0] code
);

	logic [15:0] scaled;
	logic [15:0] mask;

	// ------------------------------------------------------------
	// Linear code with range resolution
	// ------------------------------------------------------------
	always_comb begin
		scaled = {raw, 3'h0};
		unique case (mode)
			ais_pkg::M_U010, ais_pkg::M_B10, ais_pkg::M_RTD_W: begin
				mask = 16'hfff0;
			end
			ais_pkg::M_U05, ais_pkg::M_B5, ais_pkg::M_RTD_N: begin
				mask = 16'hffe0;
			end
			default: begin
				mask = 16'hfff8;
			end
		endcase
		// full scale pinned to end codes
		if (raw >= ais_pkg::RAW_FS) begin
			code = ais_pkg::CODE_POS_FS;
		end else if (raw <= -ais_pkg::RAW_FS) begin
			code = ais_pkg::CODE_NEG_FS;
		end else begin
			code = scaled & mask;
		end
		if ((mode == ais_pkg::M_I020 || mode == ais_pkg::M_I420) &&
		    raw[12]) begin
			code = ais_pkg::CODE_ZERO;
		end
	end

endmodule

`default_nettype wire

//--- rtl/ais_pkg.sv
package ais_pkg;

	// ------------------------------------------------------------
	// Geometry and timing
	// ------------------------------------------------------------
	localparam int NCH = 8;
	localparam int CLK_PERIOD_NS = 10;
	localparam longint T_SLOT_NS = 1000000;
	localparam longint T_RETRY_NS = 1000000000;
	localparam int SLOT_CYCLES = int'(T_SLOT_NS / CLK_PERIOD_NS);
	localparam int RETRY_CYCLES = int'(T_RETRY_NS / CLK_PERIOD_NS);
	localparam int T_SLOW_STEP_MS = 50;
	localparam int T_FAST_STEP_MS = 1;
	localparam logic [5:0] RTD_PASSES = 6'(T_SLOW_STEP_MS / T_FAST_STEP_MS);

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_CFG0 = 8'h00;
	localparam logic [7:0] OFF_RES0 = 8'h20;
	localparam logic [7:0] OFF_STAT = 8'h40;
	localparam logic [7:0] OFF_IEN = 8'h44;
	localparam logic [7:0] OFF_ICLR = 8'h48;
	localparam logic [7:0] OFF_CTRL = 8'h4c;
	localparam logic [7:0] OFF_SHUNT = 8'h50;
	localparam logic [7:0] OFF_NCFG = 8'h54;

	// ------------------------------------------------------------
	// Fields and reset values
	// ------------------------------------------------------------
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_DIFF_BIT = 4;
	localparam int CFG_3W_BIT = 5;
	localparam int CTRL_RUN_BIT = 0;
	localparam int ST_PASS = 0;
	localparam int ST_SLOW = 1;
	localparam int ST_OVC = 2;
	localparam logic [5:0] RST_CFG = 6'h03;
	localparam logic RST_RUN = 1'b0;
	localparam logic [2:0] RST_IEN = 3'h0;

	// ------------------------------------------------------------
	// Result codes
	// ------------------------------------------------------------
	localparam logic [15:0] CODE_POS_FS = 16'h7ff8;
	localparam logic [15:0] CODE_NEG_FS = 16'h8008;
	localparam logic [15:0] CODE_OVF = 16'h7fff;
	localparam logic [15:0] CODE_ZERO = 16'h0000;
	localparam logic signed [12:0] RAW_FS = 13'h0fff;

	typedef enum logic [3:0] {
		M_UNUSED = 4'h0,
		M_U010 = 4'h1,
		M_U05 = 4'h2,
		M_B10 = 4'h3,
		M_B5 = 4'h4,
		M_I020 = 4'h5,
		M_I420 = 4'h6,
		M_RTD_W = 4'h7,
		M_RTD_N = 4'h8,
		M_DIG = 4'h9
	} ais_mode_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} ais_apb_req_t;

	typedef struct packed {
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} ais_apb_rsp_t;

endpackage

//--- rtl/ais_seq.sv
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/10ps
`default_nettype none

module ais_seq #(
	parameter int SLOT_CYCLES = ais_pkg::SLOT_CYCLES,
	parameter int RETRY_CYCLES = ais_pkg::RETRY_CYCLES
) (
	input wire logic CLK,
	input wire logic RST_B,
	input wire ais_pkg::ais_apb_req_t APB_REQ,
	output ais_pkg::ais_apb_rsp_t APB_RSP,
	input wire logic CONV_DONE,
	input wire logic signed [12:0] CONV_DATA,
	input wire logic CONV_OVER,
	input wire logic [7:0] DIG_IN,
	output logic CONV_START,
	output logic [2:0] MUX_CH,
	output logic [5:0] CH_CFG,
	output logic [7:0] SHUNT_EN,
	output logic IRQ
);

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_CONV = 2'b01,
		S_HOLD = 2'b11,
		S_NEXT = 2'b10
	} ais_fsm_t;

	typedef struct packed {
		ais_pkg::ais_apb_rsp_t rsp;
		logic [7:0][5:0] cfg;
		logic [7:0][15:0] res;
		logic run;
		logic [7:0] shunt_off;
		logic [7:0] shunt_en;
		logic [2:0] st;
		logic [2:0] en;
		logic irq;
		ais_fsm_t fsm;
		logic [2:0] ch;
		logic [5:0] cfg_out;
		logic start;
		logic [31:0] slot;
		logic [31:0] retry;
		logic [5:0] rtd_div;
	} ais_state_t;

	localparam logic [31:0] SLOT_LOAD = 32'(SLOT_CYCLES - 2);
	localparam logic [31:0] RETRY_LOAD = 32'(RETRY_CYCLES - 1);
	localparam logic [5:0] RTD_LAST = ais_pkg::RTD_PASSES - 6'h1;

	ais_state_t s;
	ais_state_t n;
	logic [15:0] conv_code;
	logic [2:0] nxt;
	logic [2:0] first;
	logic [2:0] ev;
	logic [3:0] cur_mode;

	// ------------------------------------------------------------
	// Mode decoding
	// ------------------------------------------------------------
	function automatic logic is_analog(input logic [5:0] c);
		logic [3:0] m;
		m = c[ais_pkg::CFG_MODE_LSB +: 4];
		is_analog = (m >= 4'(ais_pkg::M_U010)) &&
		            (m <= 4'(ais_pkg::M_RTD_N));
	endfunction

	function automatic logic is_cur(input logic [5:0] c);
		logic [3:0] m;
		m = c[ais_pkg::CFG_MODE_LSB +: 4];
		is_cur = (m == 4'(ais_pkg::M_I020)) || (m == 4'(ais_pkg::M_I420));
	endfunction

	function automatic logic is_rtd(input logic [5:0] c);
		logic [3:0] m;
		m = c[ais_pkg::CFG_MODE_LSB +: 4];
		is_rtd = (m == 4'(ais_pkg::M_RTD_W)) || (m == 4'(ais_pkg::M_RTD_N));
	endfunction

	function automatic logic is_dig(input logic [5:0] c);
		is_dig = c[ais_pkg::CFG_MODE_LSB +: 4] == 4'(ais_pkg::M_DIG);
	endfunction

	// next configured channel above cur, wrapping
	function automatic logic [2:0] next_cfg(input logic [7:0][5:0] c,
	                                        input logic [2:0] cur);
		logic [2:0] k;
		logic found;
		next_cfg = cur;
		found = 1'b0;
		for (int i = 1; i <= ais_pkg::NCH; i++) begin
			k = 3'(int'(cur) + i);
			if (!found && is_analog(c[k])) begin
				next_cfg = k;
				found = 1'b1;
			end
		end
	endfunction

	function automatic logic [3:0] count_cfg(input logic [7:0][5:0] c);
		count_cfg = 4'h0;
		for (int i = 0; i < ais_pkg::NCH; i++) begin
			count_cfg = count_cfg + {3'h0, is_analog(c[i])};
		end
	endfunction

	// ------------------------------------------------------------
	// Conversion code
	// ------------------------------------------------------------
	assign cur_mode = s.cfg[s.ch][ais_pkg::CFG_MODE_LSB +: 4];

	ais_code u_code (
		.mode(cur_mode),
		.raw(CONV_DATA),
		.code(conv_code)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		n = s;
		ev = 3'h0;
		n.start = 1'b0;
		n.rsp.pready = 1'b0;
		nxt = next_cfg(s.cfg, s.ch);
		first = next_cfg(s.cfg, 3'h7);

		// APB slave, one wait state
		if (APB_REQ.psel && APB_REQ.penable && !s.rsp.pready) begin
			n.rsp.pready = 1'b1;
			n.rsp.pslverr = 1'b0;
			n.rsp.prdata = 32'h0;
			if (APB_REQ.paddr[7:5] == ais_pkg::OFF_CFG0[7:5]) begin
				n.rsp.prdata = {26'h0, s.cfg[APB_REQ.paddr[4:2]]};
				if (APB_REQ.pwrite) begin
					n.cfg[APB_REQ.paddr[4:2]] = APB_REQ.pwdata[5:0];
				end
			end else if (APB_REQ.paddr[7:5] == ais_pkg::OFF_RES0[7:5]) begin
				n.rsp.prdata = {16'h0, s.res[APB_REQ.paddr[4:2]]};
			end else begin
				unique case (APB_REQ.paddr)
					ais_pkg::OFF_STAT: begin
						n.rsp.prdata = {29'h0, s.st};
					end
					ais_pkg::OFF_IEN: begin
						n.rsp.prdata = {29'h0, s.en};
						if (APB_REQ.pwrite) begin
							n.en = APB_REQ.pwdata[2:0];
						end
					end
					ais_pkg::OFF_ICLR: begin
						if (APB_REQ.pwrite) begin
							n.st = s.st & ~APB_REQ.pwdata[2:0];
						end
					end
					ais_pkg::OFF_CTRL: begin
						n.rsp.prdata = {31'h0, s.run};
						if (APB_REQ.pwrite) begin
							n.run = APB_REQ.pwdata[ais_pkg::CTRL_RUN_BIT];
						end
					end
					ais_pkg::OFF_SHUNT: begin
						n.rsp.prdata = {24'h0, s.shunt_off};
					end
					ais_pkg::OFF_NCFG: begin
						n.rsp.prdata = {28'h0, count_cfg(s.cfg)};
					end
					default: begin
						n.rsp.pslverr = 1'b1;
					end
				endcase
			end
		end

		// retry timer recloses every open shunt
		if (s.shunt_off == 8'h00) begin
			n.retry = RETRY_LOAD;
		end else if (s.retry == 32'h0) begin
			n.shunt_off = 8'h00;
			n.retry = RETRY_LOAD;
		end else begin
			n.retry = s.retry - 32'h1;
		end

		unique case (s.fsm)
			S_IDLE: begin
				if (s.run && count_cfg(s.cfg) != 4'h0) begin
					n.ch = first;
					n.start = 1'b1;
					n.slot = SLOT_LOAD;
					n.fsm = S_CONV;
				end
			end
			S_CONV: begin
				if (s.slot != 32'h0) begin
					n.slot = s.slot - 32'h1;
				end
				if (CONV_DONE) begin
					n.fsm = S_HOLD;
					if (is_cur(s.cfg[s.ch]) &&
					    (CONV_OVER || s.shunt_off[s.ch])) begin
						n.res[s.ch] = ais_pkg::CODE_OVF;
						if (CONV_OVER) begin
							n.shunt_off[s.ch] = 1'b1;
							ev[ais_pkg::ST_OVC] = 1'b1;
						end
					end else if (!is_rtd(s.cfg[s.ch]) ||
					             s.rtd_div == RTD_LAST) begin
						n.res[s.ch] = conv_code;
					end
				end
			end
			S_HOLD: begin
				// each analog channel holds one 1 ms slot
				if (s.slot == 32'h0) begin
					n.fsm = S_NEXT;
				end else begin
					n.slot = s.slot - 32'h1;
				end
			end
			S_NEXT: begin
				if (nxt <= s.ch) begin
					ev[ais_pkg::ST_PASS] = 1'b1;
					if (s.rtd_div == RTD_LAST) begin
						n.rtd_div = 6'h0;
						ev[ais_pkg::ST_SLOW] = 1'b1;
					end else begin
						n.rtd_div = s.rtd_div + 6'h1;
					end
				end
				if (s.run && count_cfg(s.cfg) != 4'h0) begin
					n.ch = nxt;
					n.start = 1'b1;
					n.slot = SLOT_LOAD;
					n.fsm = S_CONV;
				end else begin
					n.fsm = S_IDLE;
				end
			end
		endcase

		// Digital channels follow the comparator, no slot time
		for (int i = 0; i < ais_pkg::NCH; i++) begin
			if (is_dig(n.cfg[i])) begin
				n.res[i] = DIG_IN[i] ? ais_pkg::CODE_POS_FS :
				                       ais_pkg::CODE_ZERO;
			end
			if (!is_cur(n.cfg[i])) begin
				n.shunt_off[i] = 1'b0;
			end
			n.shunt_en[i] = is_cur(n.cfg[i]) && !n.shunt_off[i];
		end

		// Set beats a simultaneous clear
		n.st = n.st | ev;
		n.irq = |(n.st & n.en);
		n.cfg_out = n.cfg[n.ch];
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			s.rsp <= '0;
			s.cfg <= {ais_pkg::NCH{ais_pkg::RST_CFG}};
			s.res <= '0;
			s.run <= ais_pkg::RST_RUN;
			s.shunt_off <= 8'h00;
			s.shunt_en <= 8'h00;
			s.st <= 3'h0;
			s.en <= ais_pkg::RST_IEN;
			s.irq <= 1'b0;
			s.fsm <= S_IDLE;
			s.ch <= 3'h0;
			s.cfg_out <= ais_pkg::RST_CFG;
			s.start <= 1'b0;
			s.slot <= 32'h0;
			s.retry <= 32'h0;
			s.rtd_div <= 6'h0;
		end else begin
			s <= n;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign APB_RSP = s.rsp;
	assign CONV_START = s.start;
	assign MUX_CH = s.ch;
	assign CH_CFG = s.cfg_out;
	assign SHUNT_EN = s.shunt_en;
	assign IRQ = s.irq;

endmodule

`default_nettype wire

//--- tb/ais_conv_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----
// Converter stand-in
// ----
module ais_conv_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic start,
	input wire logic [2:0] ch_sel,
	input wire logic signed [12:0] val,
	input wire logic [7:0] over_mask,
	input wire logic slow,
	output logic done,
	output logic signed [12:0] data,
	output logic over
);
	logic [3:0] cnt;
	logic [2:0] ch;
	// Lines toggle between answers so stale data never looks valid
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= 4'h0;
			ch <= 3'h0;
			done <= 1'b0;
			data <= 13'h0;
			over <= 1'b0;
		end else begin
			done <= cnt == 4'h1;
			data <= (cnt == 4'h1) ? val : ~data;
			over <= (cnt == 4'h1) ? over_mask[ch] : ~over;
			if (start) begin
				cnt <= slow ? 4'h9 : 4'h2;
				ch <= ch_sel;
			end else if (cnt != 4'h0) begin
				cnt <= cnt - 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

//--- tb/ais_seq_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ----
// Port checks
// ----
module ais_seq_assertions #(
	parameter int SLOT_CYCLES = 20,
	parameter int RETRY_CYCLES = 50
) (
	input wire logic CLK,
	input wire logic RST_B,
	input wire ais_pkg::ais_apb_req_t APB_REQ,
	input wire ais_pkg::ais_apb_rsp_t APB_RSP,
	input wire logic CONV_DONE,
	input wire logic CONV_OVER,
	input wire logic CONV_START,
	input wire logic [2:0] MUX_CH,
	input wire logic [5:0] CH_CFG,
	input wire logic [7:0] SHUNT_EN
);
	localparam int RMAX = RETRY_CYCLES + 2;
	int gap;
	logic seen;
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			gap <= 0;
			seen <= 1'b0;
		end else begin
			gap <= CONV_START ? 0 : gap + 1;
			seen <= seen | CONV_START;
		end
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);
	sequence s_over;
		CONV_DONE && CONV_OVER;
	endsequence
	property p_trip;
		s_over and SHUNT_EN[MUX_CH] |=> ##[0:1] !SHUNT_EN[MUX_CH];
	endproperty
	a_trip: assert property (p_trip)
		else $error("shunt stays on after overcurrent");
	for (genvar g = 0; g < 8; g++) begin : g_ch
		property p_retry;
			$fell(SHUNT_EN[g]) && ($past(CONV_DONE && CONV_OVER) ||
			$past(CONV_DONE && CONV_OVER, 2)) |-> ##[1:RMAX] SHUNT_EN[g];
		endproperty
		a_retry: assert property (p_retry)
			else $error("shunt not reclosed");
	end
	property p_gap;
		CONV_START && seen |-> gap >= SLOT_CYCLES - 1;
	endproperty
	a_gap: assert property (p_gap)
		else $error("slot too short");
	property p_analog;
		CONV_START |-> CH_CFG[3:0] inside {[4'h1:4'h8]};
	endproperty
	a_analog: assert property (p_analog)
		else $error("conversion on unconverted channel");
	property p_shunt_mode;
		CONV_START && !(CH_CFG[3:0] inside {4'h5, 4'h6}) |->
			!SHUNT_EN[MUX_CH];
	endproperty
	a_shunt_mode: assert property (p_shunt_mode)
		else $error("shunt on outside current mode");
	property p_start;
		CONV_START |=> !CONV_START ##1 $stable(MUX_CH)[*6];
	endproperty
	a_start: assert property (p_start)
		else $error("start or channel unstable");
	property p_answer;
		APB_REQ.psel && APB_REQ.penable && !APB_RSP.pready |=>
			APB_RSP.pready ##1 !APB_RSP.pready;
	endproperty
	a_answer: assert property (p_answer)
		else $error("ready late or long");
	property p_err;
		APB_RSP.pready && $past(APB_REQ.paddr[1:0] == 2'h0 &&
			APB_REQ.paddr <= 8'h54) |-> !APB_RSP.pslverr;
	endproperty
	a_err: assert property (p_err)
		else $error("error on mapped address");
endmodule
`default_nettype wire

//--- tb/analog_input_scan_sequencer_test.sv
`timescale 1ns/10ps
`default_nettype none
// ----
// Sequencer bench
// ----
module analog_input_scan_sequencer_test;
	typedef struct packed {
		logic [3:0] mode;
		logic [12:0] raw;
		logic [15:0] code;
	} ais_row_t;
	ais_row_t rows[12] = '{
		'{4'h3, 13'h0fff, 16'h7ff8}, '{4'h3, 13'h1001, 16'h8008},
		'{4'h3, 13'h0000, 16'h0000}, '{4'h3, 13'h0067, 16'h0330},
		'{4'h1, 13'h0067, 16'h0330}, '{4'h2, 13'h0067, 16'h0320},
		'{4'h4, 13'h0067, 16'h0320}, '{4'h5, 13'h0067, 16'h0338},
		'{4'h6, 13'h1fce, 16'h0000}, '{4'h7, 13'h0067, 16'h0330},
		'{4'h8, 13'h1001, 16'h8008}, '{4'h9, 13'h0000, 16'h7ff8}};
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	ais_pkg::ais_apb_req_t req = '0;
	ais_pkg::ais_apb_rsp_t rsp;
	logic done, over, start, irq, er;
	logic signed [12:0] data;
	logic signed [12:0] val = 13'h0;
	logic [7:0] omask = 8'h0;
	logic [7:0] dig = 8'hff;
	logic slow = 1'b0;
	logic [2:0] mux, nx;
	logic [5:0] cfg;
	logic [7:0] shunt;
	logic [31:0] rd;
	int n;
	int failures = 0;
	int checks_done = 0;
	logic [2:0] chs[$];
	logic [31:0] tms[$];
	always #5 clk = ~clk;
	ais_seq #(.SLOT_CYCLES(20), .RETRY_CYCLES(50)) i_ais_seq (
		.CLK(clk), .RST_B(rst_b), .APB_REQ(req), .APB_RSP(rsp),
		.CONV_DONE(done), .CONV_DATA(data), .CONV_OVER(over),
		.DIG_IN(dig), .CONV_START(start), .MUX_CH(mux),
		.CH_CFG(cfg), .SHUNT_EN(shunt), .IRQ(irq));
	ais_conv_model i_ais_conv_model (
		.clk(clk), .rst_b(rst_b), .start(start), .ch_sel(mux),
		.val(val), .over_mask(omask), .slow(slow), .done(done),
		.data(data), .over(over));
	always @(posedge clk) begin
		if (start === 1'b1) begin
			chs.push_back(mux);
			tms.push_back(32'($time));
		end
	end
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		req.penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (rsp.pready !== 1'b1 && k < 50);
		rd = rsp.prdata;
		er = rsp.pslverr;
		req <= '0;
		@(posedge clk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clk);
		failures++;
		conclude();
	end
	initial begin
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rdchk(ais_pkg::OFF_CFG0, 32'h3);
		rdchk(ais_pkg::OFF_NCFG, 32'h8);
		rdchk(ais_pkg::OFF_CTRL, 32'h0);
		rdchk(8'h80, 32'h0);
		chk({31'h0, er}, 32'h1);
		for (int c = 1; c < 8; c++)
			apb(1'b1, 8'(4 * c), 32'h0);
		apb(1'b1, ais_pkg::OFF_CTRL, 32'h1);
		foreach (rows[i]) begin
			apb(1'b1, ais_pkg::OFF_CFG0, {28'h0, rows[i].mode});
			val <= rows[i].raw;
			repeat (1200) @(posedge clk);
			rdchk(ais_pkg::OFF_RES0, {16'h0, rows[i].code});
		end
		rdchk(ais_pkg::OFF_NCFG, 32'h0);
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b1, 8'h04, 32'h1);
		apb(1'b1, 8'h14, 32'h5);
		apb(1'b1, 8'h18, 32'h7);
		rdchk(ais_pkg::OFF_NCFG, 32'h3);
		slow <= 1'b1;
		repeat (100) @(posedge clk);
		chs.delete();
		tms.delete();
		repeat (150) @(posedge clk);
		for (int k = 0; k < 3; k++) begin
			nx = chs[k] == 3'h1 ? 3'h5 : chs[k] == 3'h5 ? 3'h6 : 3'h1;
			chk(32'(chs[k + 1]), 32'(nx));
			chk(tms[k + 3] - tms[k], 32'd600);
		end
		apb(1'b1, ais_pkg::OFF_ICLR, 32'h2);
		n = 0;
		do begin
			apb(1'b0, ais_pkg::OFF_STAT, 32'h0);
			n++;
		end while (rd[1] !== 1'b1 && n < 1000);
		chk(rd & 32'h2, 32'h2);
		apb(1'b1, ais_pkg::OFF_ICLR, 32'h2);
		repeat (2400) @(posedge clk);
		apb(1'b0, ais_pkg::OFF_STAT, 32'h0);
		chk(rd & 32'h2, 32'h0);
		repeat (900) @(posedge clk);
		apb(1'b0, ais_pkg::OFF_STAT, 32'h0);
		chk(rd & 32'h2, 32'h2);
		omask <= 8'h20;
		repeat (200) @(posedge clk);
		rdchk(8'h34, 32'h7fff);
		apb(1'b0, ais_pkg::OFF_STAT, 32'h0);
		chk(rd & 32'h4, 32'h4);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, ais_pkg::OFF_IEN, 32'h4);
		chk({31'h0, irq}, 32'h1);
		omask <= 8'h0;
		val <= 13'h0067;
		repeat (300) @(posedge clk);
		rdchk(ais_pkg::OFF_SHUNT, 32'h0);
		rdchk(8'h34, 32'h0338);
		apb(1'b1, ais_pkg::OFF_ICLR, 32'h4);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		rst_b <= 1'b0;
		@(posedge clk);
		chk({18'h0, start, shunt, cfg}, {18'h0, 1'b0, 8'h0, 6'h03});
		conclude();
	end
endmodule
bind ais_seq ais_seq_assertions #(.SLOT_CYCLES(SLOT_CYCLES),
	.RETRY_CYCLES(RETRY_CYCLES)) i_ais_seq_assertions (.CLK(CLK),
	.RST_B(RST_B), .APB_REQ(APB_REQ), .APB_RSP(APB_RSP),
	.CONV_DONE(CONV_DONE), .CONV_OVER(CONV_OVER),
	.CONV_START(CONV_START), .MUX_CH(MUX_CH), .CH_CFG(CH_CFG),
	.SHUNT_EN(SHUNT_EN));
`default_nettype wire
